/* stop_mode_power_controller.sv */
/*
 * Stop mode power controller: selects stop state on STOP, controls
 * regulator and clock gating, I/O latches and deep-stop recovery.
 * Assumes wake pins arrive asynchronously, CPU strobes are synchronous.
 */
// Decided for this implementation: the placing of the registers and the strobed register port.
// Functional notes
// - STOP with stop_allow clear forces illegal opcode reset, no stop entry.
// - Both stops halt bus/CPU clocks; regulator standby light, powerdown deep.
// - Debug enabled: STOP enters light stop with debug logic kept alive.
// - Both detect bits set: light stop with regulator fully active.
// - Otherwise deep stop if powerdown select set, else light stop.
// - Deep stop entry latches I/O controls; display keeps driving if enabled.
// - Deep stop exits only on reset pin, wake pin low, or RTC interrupt.
// - Deep stop wake restarts as power-on reset, keeping power regs.
// - Deep stop restart holds reset while supply below detect trip point.
// - Deep stop wake sets flag; flag and latches hold until ack written.
// - On ack latches open; pins follow current port and peripheral setup.
// - Light stop retains all registers, logic, RAM and pin states.
// - Light stop exits by reset pin (reset) or enabled wake interrupt.
// - Debug enabled: debug clocks and full regulation kept; deep becomes light.
// - Stopped: status commands report error; BACKGROUND wakes only if debug on.
// - Both detect bits set: regulator active, deep request becomes light.
// - Powerdown select and low-power request are mutually exclusive on write; here one write setting both while both are clear sets both.
// - STOP in low-power run enters light; irq exit returns per wake bit.
// - Light stop from low-power run, irq with wake bit: normal run, clear bits.
// - Low-power run needs debug off, request, no select, not both detect.
// - Wait stops CPU clock; low-power wait slows peripherals, regulator standby.
// - Debug enabled turns low-power run or wait into normal run or wait.
// - Any reset in low-power run returns to normal run, clears bits.
`timescale 1ns/100ps
module stop_mode_power_controller
  import power_mode_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       stopExec,
  input  wire logic       waitExec,
  input  wire logic       irqWake,
  input  wire logic       resetPin_n,
  input  wire logic       externalWakePin_n,
  input  wire logic       batteryRtcIrq,
  input  wire logic       supplyBelowTrip,
  input  wire logic       debugStatusCmd,
  input  wire logic       debugBackgroundCmd,
  output logic      [1:0] debugStatus,
  output logic            debugBackgroundEntry,
  output logic            illegalOpReset,
  output logic            porRestart,
  output logic            cpuClockEn,
  output logic            busClockEn,
  output logic            periphClockEn,
  output logic            periphClockSlow,
  output logic            debugClockEn,
  output logic            regulatorStandby,
  output logic            regulatorPowerdown,
  output logic            externalBypassLowpower,
  output logic            ioLatchHold,
  output logic            displayDriveKeep,
  output logic      [2:0] currentMode
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pinMeta_r;
  logic [2:0] pinSync_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pinMeta_r <= 3'h3;
      pinSync_r <= 3'h3;
    end else begin
      pinMeta_r <= {supplyBelowTrip, externalWakePin_n, resetPin_n};
      pinSync_r <= pinMeta_r;
    end
  end

  logic resetPinLow;
  logic wakePinLow;
  logic supplyLow;
  assign resetPinLow = ~pinSync_r[0];
  assign wakePinLow  = ~pinSync_r[1];
  assign supplyLow   = pinSync_r[2];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic       stopAllow_r;
  logic       lowvoltDetectEnable_r;
  logic       lowvoltDetectInStop_r;
  logic       partialPowerdownSelect_r;
  logic       partialPowerdownFlag_r;
  logic       lowpowerRunRequest_r;
  logic       lowpowerWakeOnIrq_r;
  logic       debugActiveEnable_r;
  pmode_e     mode_r;
  pmode_e     mode_nxt;
  logic       porHold_r;

  logic lvdBoth;
  logic lprStatus;
  logic wrSysopt;
  logic wrPm1;
  logic wrPm2;
  logic wrDbg;
  logic stopped;
  logic deepWake;
  logic lightIrqExit;
  logic lightStopWake;

  assign lvdBoth  = lowvoltDetectEnable_r & lowvoltDetectInStop_r;
  assign wrSysopt = regWrite && regAddr == ADDR_SYSOPT1;
  assign wrPm1    = regWrite && regAddr == ADDR_PMCTRL1;
  assign wrPm2    = regWrite && regAddr == ADDR_PMCTRL2;
  assign wrDbg    = regWrite && regAddr == ADDR_DBGCTRL;
  assign stopped  = mode_r == ST_LIGHT_STOP || mode_r == ST_DEEP_STOP;
  assign deepWake = mode_r == ST_DEEP_STOP &&
                    (resetPinLow || wakePinLow || batteryRtcIrq);
  assign lightIrqExit  = mode_r == ST_LIGHT_STOP && irqWake;
  assign lightStopWake = lightIrqExit && lowpowerRunRequest_r && lowpowerWakeOnIrq_r;

  // Low-power run is live only when every qualifying condition holds.
  assign lprStatus = lowpowerRunRequest_r & ~debugActiveEnable_r &
                     ~partialPowerdownSelect_r & ~lvdBoth;

  // Stop enable is the only register cleared by the deep-stop restart;
  // the power management and debug control registers are retained.
  always_ff @(posedge mclk) begin
    if (reset || deepWake) begin
      stopAllow_r <= SYSOPT1_RESET[STOP_ALLOW_BIT];
    end else if (wrSysopt) begin
      stopAllow_r <= regWrData[STOP_ALLOW_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      lowvoltDetectEnable_r <= PMCTRL1_RESET[LVD_ENABLE_BIT];
      lowvoltDetectInStop_r <= PMCTRL1_RESET[LVD_IN_STOP_BIT];
    end else if (wrPm1) begin
      lowvoltDetectEnable_r <= regWrData[LVD_ENABLE_BIT];
      lowvoltDetectInStop_r <= regWrData[LVD_IN_STOP_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      debugActiveEnable_r <= 1'b0;
    end else if (wrDbg) begin
      debugActiveEnable_r <= regWrData[DBG_ENABLE_BIT];
    end
  end

  // Each select bit refuses to set while the other is already set.
  always_ff @(posedge mclk) begin
    if (reset) begin
      partialPowerdownSelect_r <= PMCTRL2_RESET[PPD_SELECT_BIT];
      lowpowerWakeOnIrq_r      <= PMCTRL2_RESET[LP_WAKE_IRQ_BIT];
    end else if (wrPm2) begin
      lowpowerWakeOnIrq_r <= regWrData[LP_WAKE_IRQ_BIT];
      if (!(regWrData[PPD_SELECT_BIT] && lowpowerRunRequest_r)) begin
        partialPowerdownSelect_r <= regWrData[PPD_SELECT_BIT];
      end
    end
  end

  // Reset and wake-with-irq-exit both drop the low-power request.
  always_ff @(posedge mclk) begin
    if (reset || resetPinLow || porHold_r) begin
      lowpowerRunRequest_r <= 1'b0;
    end else if (lightStopWake || (mode_r == ST_LP_WAIT && irqWake && lowpowerWakeOnIrq_r)) begin
      lowpowerRunRequest_r <= 1'b0;
    end else if (wrPm2) begin
      if (!(regWrData[LPR_REQUEST_BIT] && partialPowerdownSelect_r)) begin
        lowpowerRunRequest_r <= regWrData[LPR_REQUEST_BIT];
      end
    end
  end

  // Flag set on deep-stop wake wins over an acknowledge in the same cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      partialPowerdownFlag_r <= 1'b0;
    end else if (deepWake) begin
      partialPowerdownFlag_r <= 1'b1;
    end else if (wrPm2 && regWrData[PPD_ACK_BIT]) begin
      partialPowerdownFlag_r <= 1'b0;
    end
  end

  // Restart after deep stop: held as in power-on reset until supply recovers.
  always_ff @(posedge mclk) begin
    if (reset) begin
      porHold_r <= 1'b0;
    end else if (deepWake) begin
      porHold_r <= 1'b1;
    end else if (porHold_r && !supplyLow) begin
      porHold_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      ST_RUN, ST_LP_RUN: begin
        if (stopExec && stopAllow_r) begin
          if (debugActiveEnable_r) begin
            mode_nxt = ST_LIGHT_STOP;
          end else if (lvdBoth) begin
            mode_nxt = ST_LIGHT_STOP;
          end else if (partialPowerdownSelect_r && !lowpowerRunRequest_r) begin
            mode_nxt = ST_DEEP_STOP;
          end else begin
            mode_nxt = ST_LIGHT_STOP;
          end
        end else if (waitExec) begin
          mode_nxt = lprStatus ? ST_LP_WAIT : ST_WAIT;
        end else begin
          mode_nxt = lprStatus ? ST_LP_RUN : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (irqWake || (debugBackgroundCmd && debugActiveEnable_r)) begin
          mode_nxt = ST_RUN;
        end
      end
      ST_LP_WAIT: begin
        if (irqWake) begin
          mode_nxt = lowpowerWakeOnIrq_r ? ST_RUN : ST_LP_RUN;
        end
      end
      ST_LIGHT_STOP: begin
        if (irqWake) begin
          mode_nxt = (lprStatus && !lowpowerWakeOnIrq_r) ? ST_LP_RUN : ST_RUN;
        end else if (debugBackgroundCmd && debugActiveEnable_r) begin
          mode_nxt = ST_RUN;
        end
      end
      ST_DEEP_STOP: begin
        if (deepWake) begin
          mode_nxt = ST_RUN;
        end
      end
    endcase
  end

  // Reset pin forces run mode from any mode and clears the low-power request (from deep stop also stop enable); light stop retains state otherwise.
  always_ff @(posedge mclk) begin
    if (reset || resetPinLow) begin
      mode_r <= ST_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      illegalOpReset <= 1'b0;
    end else begin
      illegalOpReset <= stopExec && !stopAllow_r &&
                        (mode_r == ST_RUN || mode_r == ST_LP_RUN);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      debugStatus          <= DBG_STAT_OK;
      debugBackgroundEntry <= 1'b0;
    end else begin
      debugStatus <= (debugStatusCmd && (stopped || mode_r == ST_WAIT || mode_r == ST_LP_WAIT))
                     ? DBG_STAT_STOPPED : DBG_STAT_OK;
      debugBackgroundEntry <= debugBackgroundCmd && debugActiveEnable_r && !resetPinLow;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_SYSOPT1: regRdData <= {7'h00, stopAllow_r};
        ADDR_PMCTRL1: regRdData <= {6'h00, lowvoltDetectInStop_r, lowvoltDetectEnable_r};
        ADDR_PMCTRL2: regRdData <= {2'h0, lowpowerWakeOnIrq_r, lprStatus, lowpowerRunRequest_r,
                                    partialPowerdownFlag_r, 1'b0, partialPowerdownSelect_r};
        ADDR_DBGCTRL: regRdData <= {7'h00, debugActiveEnable_r};
        ADDR_MODE:    regRdData <= {5'h00, currentMode};
        default:      regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  assign porRestart             = porHold_r || (porHold_r && supplyLow);
  assign cpuClockEn             = mode_r == ST_RUN || mode_r == ST_LP_RUN;
  assign busClockEn             = !stopped;
  assign periphClockEn          = !stopped;
  assign periphClockSlow        = mode_r == ST_LP_RUN || mode_r == ST_LP_WAIT;
  assign debugClockEn           = debugActiveEnable_r && !(mode_r == ST_DEEP_STOP);
  assign regulatorStandby       = (mode_r == ST_LIGHT_STOP && !debugActiveEnable_r && !lvdBoth) ||
                                  periphClockSlow;
  assign regulatorPowerdown     = mode_r == ST_DEEP_STOP;
  assign externalBypassLowpower = periphClockSlow;
  assign ioLatchHold            = mode_r == ST_DEEP_STOP || partialPowerdownFlag_r;
  assign displayDriveKeep       = mode_r == ST_DEEP_STOP;

  always_comb begin
    currentMode = MODE_RUN;
    unique case (mode_r)
      ST_RUN:        currentMode = MODE_RUN;
      ST_LP_RUN:     currentMode = MODE_LP_RUN;
      ST_WAIT:       currentMode = MODE_WAIT;
      ST_LP_WAIT:    currentMode = MODE_LP_WAIT;
      ST_LIGHT_STOP: currentMode = MODE_LIGHT_STOP;
      ST_DEEP_STOP:  currentMode = MODE_DEEP_STOP;
    endcase
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_illegal_stop: assert property (@(posedge mclk) disable iff (reset)
    (stopExec && !stopAllow_r && mode_r == ST_RUN && !resetPinLow) |=> illegalOpReset && mode_r == ST_RUN)
    else $error("illegal stop did not reset");
  a_debug_light: assert property (@(posedge mclk) disable iff (reset)
    (stopExec && stopAllow_r && debugActiveEnable_r && mode_r == ST_RUN && !resetPinLow)
    |=> mode_r == ST_LIGHT_STOP && debugClockEn && !regulatorStandby)
    else $error("debug stop not light");
  a_lvd_light: assert property (@(posedge mclk) disable iff (reset)
    (stopExec && stopAllow_r && lvdBoth && mode_r == ST_RUN && !resetPinLow)
    |=> mode_r == ST_LIGHT_STOP && !regulatorStandby)
    else $error("detect stop not light");
  a_deep_entry: assert property (@(posedge mclk) disable iff (reset)
    (stopExec && stopAllow_r && !debugActiveEnable_r && !lvdBoth && partialPowerdownSelect_r
     && mode_r == ST_RUN && !resetPinLow) |=> regulatorPowerdown && ioLatchHold)
    else $error("deep stop not entered");
  a_deep_hold: assert property (@(posedge mclk) disable iff (reset)
    (mode_r == ST_DEEP_STOP && !deepWake && !resetPinLow) |=> mode_r == ST_DEEP_STOP)
    else $error("deep stop left without wake");
  a_flag_latch: assert property (@(posedge mclk) disable iff (reset)
    deepWake |=> partialPowerdownFlag_r && ioLatchHold ##1 (ioLatchHold || $past(wrPm2)))
    else $error("flag not set on wake");
  a_mutual_excl: assert property (@(posedge mclk) disable iff (reset)
    !(partialPowerdownSelect_r && lowpowerRunRequest_r))
    else $error("select and request both set");
  a_stop_clocks: assert property (@(posedge mclk) disable iff (reset)
    stopped |-> !busClockEn && !cpuClockEn && !periphClockEn && (regulatorPowerdown == (mode_r == ST_DEEP_STOP))
    && (regulatorStandby || regulatorPowerdown || debugActiveEnable_r || lvdBoth))
    else $error("clocks or regulator wrong in stop");
  a_lp_wake: assert property (@(posedge mclk) disable iff (reset)
    (lightStopWake && !resetPinLow) |=> mode_r == ST_RUN && !lowpowerRunRequest_r)
    else $error("wake did not clear low power");
  a_status_error: assert property (@(posedge mclk) disable iff (reset)
    (debugStatusCmd && stopped) |=> debugStatus == DBG_STAT_STOPPED)
    else $error("status command not refused while stopped");
  a_pin_reset: assert property (@(posedge mclk) disable iff (reset)
    resetPinLow |=> mode_r == ST_RUN && !lowpowerRunRequest_r)
    else $error("reset pin did not return to run");
  c_deep_cycle: cover property (@(posedge mclk) mode_r == ST_DEEP_STOP ##1 mode_r == ST_RUN);
  c_light_cycle: cover property (@(posedge mclk) mode_r == ST_LIGHT_STOP ##1 mode_r == ST_LP_RUN);
  c_lp_wait: cover property (@(posedge mclk) mode_r == ST_LP_WAIT);

endmodule : stop_mode_power_controller

/* power_mode_pkg.sv */
/*
 * Shared constants and types for the stop mode power controller.
 * Assumes a single 25 MHz clock domain and a plain register port.
 */
package power_mode_pkg;

  // Register offsets on the plain register port (word indices).
  localparam logic [3:0] ADDR_SYSOPT1  = 4'h0;
  localparam logic [3:0] ADDR_PMCTRL1  = 4'h1;
  localparam logic [3:0] ADDR_PMCTRL2  = 4'h2;
  localparam logic [3:0] ADDR_DBGCTRL  = 4'h3;
  localparam logic [3:0] ADDR_MODE     = 4'h4;

  // Field positions in system_option_one.
  localparam int STOP_ALLOW_BIT   = 0;
  // Field positions in power_mgmt_ctrl_one.
  localparam int LVD_ENABLE_BIT   = 0;
  localparam int LVD_IN_STOP_BIT  = 1;
  // Field positions in power_mgmt_ctrl_two.
  localparam int PPD_SELECT_BIT   = 0;
  localparam int PPD_ACK_BIT      = 1;
  localparam int PPD_FLAG_BIT     = 2;
  localparam int LPR_REQUEST_BIT  = 3;
  localparam int LPR_STATUS_BIT   = 4;
  localparam int LP_WAKE_IRQ_BIT  = 5;
  // Field positions in debug_status_control.
  localparam int DBG_ENABLE_BIT   = 0;

  // Reset values.
  localparam logic [7:0] SYSOPT1_RESET = 8'h00;
  localparam logic [7:0] PMCTRL1_RESET = 8'h00;
  localparam logic [7:0] PMCTRL2_RESET = 8'h00;

  // Encoded current mode.
  localparam logic [2:0] MODE_RUN        = 3'h0;
  localparam logic [2:0] MODE_LP_RUN     = 3'h1;
  localparam logic [2:0] MODE_WAIT       = 3'h2;
  localparam logic [2:0] MODE_LP_WAIT    = 3'h3;
  localparam logic [2:0] MODE_LIGHT_STOP = 3'h4;
  localparam logic [2:0] MODE_DEEP_STOP  = 3'h5;

  // Debug status answers for memory-access-with-status commands.
  localparam logic [1:0] DBG_STAT_OK      = 2'h0;
  localparam logic [1:0] DBG_STAT_STOPPED = 2'h1;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_LP_RUN,
    ST_WAIT,
    ST_LP_WAIT,
    ST_LIGHT_STOP,
    ST_DEEP_STOP
  } pmode_e;

endpackage : power_mode_pkg

/* wake_source_model.sv */
/*
 * Model of the wake sources around the power controller: reset pin,
 * external wake pin and battery RTC interrupt.
 * Assumes one-cycle requests from the bench on the controller clock.
 */
`timescale 1ns/100ps
module wake_source_model (
  input  wire logic       mclk,
  input  wire logic [1:0] wakeReq,
  output logic            resetPin_n,
  output logic            externalWakePin_n,
  output logic            batteryRtcIrq
);
  logic [2:0] holdCnt_r = 3'h0;
  logic [1:0] src_r     = 2'h0;

  // Sources are held for four cycles so the two-stage synchroniser sees them.
  always_ff @(posedge mclk) begin
    if (wakeReq != 2'h0) begin
      holdCnt_r <= 3'h4;
      src_r     <= wakeReq;
    end else if (holdCnt_r != 3'h0) begin
      holdCnt_r <= holdCnt_r - 3'h1;
    end
  end

  // Released pins return to their pulled-up idle level.
  assign resetPin_n        = !(holdCnt_r != 3'h0 && src_r == 2'h1);
  assign externalWakePin_n = !(holdCnt_r != 3'h0 && src_r == 2'h2);
  assign batteryRtcIrq     = holdCnt_r != 3'h0 && src_r == 2'h3;
endmodule : wake_source_model

/* tb_stop_mode_power_controller.sv */
/*
 * Self-checking bench for the stop mode power controller.
 * Assumes the wake source model and one 25 MHz clock with sync reset.
 */
`timescale 1ns/100ps
module tb_stop_mode_power_controller;
  import power_mode_pkg::*;
  logic        mclk, reset, regWrite, regRead, stopExec, waitExec, irqWake;
  logic        supplyBelowTrip, debugStatusCmd, debugBackgroundCmd, debugBackgroundEntry;
  logic        illegalOpReset, porRestart, cpuClockEn, busClockEn, periphClockEn;
  logic        periphClockSlow, debugClockEn, regulatorStandby, regulatorPowerdown;
  logic        externalBypassLowpower, ioLatchHold, displayDriveKeep, deep;
  logic        resetPin_n, externalWakePin_n, batteryRtcIrq;
  logic [1:0]  debugStatus, wakeReq;
  logic [2:0]  currentMode;
  logic [3:0]  regAddr, b;
  logic [7:0]  regWrData, regRdData, rd;
  logic [31:0] seed;
  int          miscompares, n_tests, n;

  stop_mode_power_controller i_stop_mode_power_controller (.mclk, .reset, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .stopExec, .waitExec, .irqWake, .resetPin_n, .externalWakePin_n,
    .batteryRtcIrq, .supplyBelowTrip, .debugStatusCmd, .debugBackgroundCmd, .debugStatus,
    .debugBackgroundEntry, .illegalOpReset, .porRestart, .cpuClockEn, .busClockEn, .periphClockEn,
    .periphClockSlow, .debugClockEn, .regulatorStandby, .regulatorPowerdown, .externalBypassLowpower,
    .ioLatchHold, .displayDriveKeep, .currentMode);
  wake_source_model i_wake_source_model (.mclk, .wakeReq, .resetPin_n, .externalWakePin_n, .batteryRtcIrq);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Bits are debug enable, detect in stop, detect enable, powerdown select.
  function automatic logic [2:0] expStop(input logic [3:0] c);
    if (c[3] || (c[2] && c[1]) || !c[0]) return MODE_LIGHT_STOP;
    return MODE_DEEP_STOP;
  endfunction : expStop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic regWr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge mclk);
    regWrite  <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rd = regRdData;
  endtask : regRd

  // Codes: 0 stop, 1 wait, 2 status command, 3 background command.
  task automatic cpuOp(input int k);
    @(posedge mclk);
    {debugBackgroundCmd, debugStatusCmd, waitExec, stopExec} <= 4'h1 << k;
    @(posedge mclk);
    {debugBackgroundCmd, debugStatusCmd, waitExec, stopExec} <= 4'h0;
    #1;
  endtask : cpuOp

  task automatic waitMode(input logic [2:0] m);
    int k;
    k = 0;
    #1;
    while (currentMode !== m && k < 20) begin
      @(posedge mclk);
      #1 k++;
    end
    check(currentMode, m);
  endtask : waitMode

  task automatic wake(input logic [1:0] code);
    @(posedge mclk);
    wakeReq <= code;
    @(posedge mclk);
    wakeReq <= 2'h0;
  endtask : wake

  task automatic irqExit(input logic [2:0] m);
    @(posedge mclk);
    irqWake <= 1'b1;
    waitMode(m);
    @(posedge mclk);
    irqWake <= 1'b0;
  endtask : irqExit

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    finish_test();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    {reset, regWrite, regRead, stopExec, waitExec, irqWake} = 6'h20;
    {supplyBelowTrip, debugStatusCmd, debugBackgroundCmd} = 3'h0;
    {regAddr, regWrData, wakeReq} = 14'h0;
    seed = 32'd80374;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    regRd(ADDR_SYSOPT1);
    check(rd, SYSOPT1_RESET);
    regRd(ADDR_PMCTRL1);
    check(rd, PMCTRL1_RESET);
    regRd(ADDR_PMCTRL2);
    check(rd, PMCTRL2_RESET);
    regRd(ADDR_MODE);
    check(rd, {5'h00, MODE_RUN});
    regRd(4'hF);
    check(rd, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      b = (i < 16) ? i[3:0] : seed[3:0];
      deep = (expStop(b) == MODE_DEEP_STOP);
      regWr(ADDR_DBGCTRL, {7'h00, b[3]});
      regWr(ADDR_PMCTRL1, {6'h00, b[2], b[1]});
      regWr(ADDR_PMCTRL2, {7'h00, b[0]});
      regWr(ADDR_SYSOPT1, 8'h01);
      cpuOp(0);
      check(currentMode, expStop(b));
      check({cpuClockEn, busClockEn, regulatorPowerdown, ioLatchHold, displayDriveKeep, debugClockEn},
            {2'b00, deep, deep, deep, b[3]});
      check(regulatorStandby, !deep && !b[3] && !(b[2] && b[1]));
      cpuOp(2);
      check(debugStatus, DBG_STAT_STOPPED);
      if (deep) begin
        @(posedge mclk);
        irqWake <= 1'b1;
        repeat (4) @(posedge mclk);
        irqWake <= 1'b0;
        supplyBelowTrip <= (i == 1);
        #1 check(currentMode, MODE_DEEP_STOP);
        wake(i[1] ? 2'h3 : 2'h2);
        waitMode(MODE_RUN);
        repeat (4) @(posedge mclk);
        #1 check(porRestart, i == 1);
        @(posedge mclk);
        supplyBelowTrip <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 check(porRestart, 1'b0);
        regRd(ADDR_SYSOPT1);
        check(rd, SYSOPT1_RESET);
        regRd(ADDR_PMCTRL1);
        check(rd, {6'h00, b[2], b[1]});
        regRd(ADDR_PMCTRL2);
        check(rd[PPD_FLAG_BIT], 1'b1);
        check(ioLatchHold, 1'b1);
        // Ports, peripherals and oscillator would be restored before the acknowledge.
        regWr(ADDR_PMCTRL2, 8'h02);
        #1 check(ioLatchHold, 1'b0);
        regRd(ADDR_PMCTRL2);
        check(rd, 8'h00);
      end else begin
        cpuOp(3);
        n = 0;
        repeat (3) begin
          if (debugBackgroundEntry === 1'b1) n++;
          @(posedge mclk);
          #1;
        end
        check(n[7:0], {7'h00, b[3]});
        if (b[3]) begin
          waitMode(MODE_RUN);
        end else if (i > 23) begin
          wake(2'h1);
          waitMode(MODE_RUN);
        end else begin
          irqExit(MODE_RUN);
          regRd(ADDR_PMCTRL1);
          check(rd, {6'h00, b[2], b[1]});
        end
      end
    end
    $display("test stop selection done");
    regWr(ADDR_PMCTRL2, 8'h00);
    regWr(ADDR_DBGCTRL, 8'h00);
    regWr(ADDR_PMCTRL1, 8'h00);
    regWr(ADDR_PMCTRL2, 8'h08);
    waitMode(MODE_LP_RUN);
    check({externalBypassLowpower, regulatorStandby}, 2'b11);
    regWr(ADDR_PMCTRL2, 8'h09);
    regRd(ADDR_PMCTRL2);
    check(rd, 8'h18);
    cpuOp(1);
    check(currentMode, MODE_LP_WAIT);
    check({cpuClockEn, periphClockSlow, regulatorStandby}, 3'b011);
    irqExit(MODE_LP_RUN);
    regWr(ADDR_SYSOPT1, 8'h01);
    cpuOp(0);
    check(currentMode, MODE_LIGHT_STOP);
    irqExit(MODE_LP_RUN);
    regWr(ADDR_PMCTRL2, 8'h28);
    cpuOp(0);
    irqExit(MODE_RUN);
    regRd(ADDR_PMCTRL2);
    check(rd, 8'h20);
    regWr(ADDR_PMCTRL2, 8'h01);
    regWr(ADDR_PMCTRL2, 8'h09);
    regRd(ADDR_PMCTRL2);
    check(rd, 8'h01);
    $display("test low power run done");
    regWr(ADDR_PMCTRL2, 8'h00);
    regWr(ADDR_DBGCTRL, 8'h01);
    regWr(ADDR_PMCTRL2, 8'h08);
    repeat (3) @(posedge mclk);
    #1 check(currentMode, MODE_RUN);
    cpuOp(1);
    check(currentMode, MODE_WAIT);
    check({cpuClockEn, periphClockEn, periphClockSlow, regulatorStandby}, 4'b0100);
    irqExit(MODE_RUN);
    regWr(ADDR_DBGCTRL, 8'h00);
    regWr(ADDR_PMCTRL2, 8'h08);
    waitMode(MODE_LP_RUN);
    wake(2'h1);
    waitMode(MODE_RUN);
    regRd(ADDR_PMCTRL2);
    check(rd, 8'h00);
    regWr(ADDR_SYSOPT1, 8'h00);
    cpuOp(0);
    n = 0;
    repeat (3) begin
      if (illegalOpReset === 1'b1) n++;
      @(posedge mclk);
      #1;
    end
    check(n[7:0], 8'h01);
    check(currentMode, MODE_RUN);
    $display("test wait, debug and refusal done");
    finish_test();
  end
endmodule : tb_stop_mode_power_controller
